// ---- rtl/branch_spec_defines.vh ----
// Constants for the branch prediction and speculation control block.
// Assumes inclusion by bare name from design files.
`ifndef BRANCH_SPEC_DEFINES_VH
`define BRANCH_SPEC_DEFINES_VH

// Target buffer geometry
`define BTB_ENTRIES      512
`define BTB_WAYS         4
`define BTB_SET_BITS     7
`define PC_IDX_LSB       2
// History table
`define BHT_IDX_BITS     10
`define CTR_RESET        2'h1
`define CTR_TAKEN_BIT    1
// Return stack
`define RSTACK_DEPTH     8
`define RSTACK_PTR_BITS  3
// Speculation
`define SPEC_MAX_LEVEL   3'h4
`define FPQ_DEPTH        3'h4
`define WBUF_DEPTH       3'h6
// Misprediction penalties in cycles
`define PENALTY_EX       3'h4
`define PENALTY_WB       3'h5

`endif

// ---- rtl/return_stack.v ----
// Eight-entry return address stack.
// Assumes push and pop come from fetch logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "branch_spec_defines.vh"

module return_stack
#(
    parameter AW    = 32,
    parameter DEPTH = `RSTACK_DEPTH
)
(
    // Clock and reset
    input  wire          clk_i,
    input  wire          rst_n_i,
    input  wire          ce_i,
    // Stack access
    input  wire          push_i,
    input  wire [AW-1:0] push_addr_i,
    input  wire          pop_i,
    output wire          nonempty_o,
    output wire [AW-1:0] top_o
);

    reg [AW-1:0]                 mem_reg [0:DEPTH-1];
    reg [`RSTACK_PTR_BITS-1:0]   sp_reg;
    reg [`RSTACK_PTR_BITS:0]     cnt_reg;
    wire [`RSTACK_PTR_BITS-1:0]  top_idx;

    assign top_idx    = sp_reg - 3'h1;
    assign top_o      = mem_reg[top_idx];
    assign nonempty_o = (cnt_reg != 4'h0);

    // Oldest entry is overwritten when full
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sp_reg  <= 3'h0;
            cnt_reg <= 4'h0;
        end
        else if (ce_i)
        begin
            if (push_i)
            begin
                sp_reg <= sp_reg + 3'h1;
                if (cnt_reg != DEPTH)
                    cnt_reg <= cnt_reg + 4'h1;
            end
            else if (pop_i && nonempty_o)
            begin
                sp_reg  <= top_idx;
                cnt_reg <= cnt_reg - 4'h1;
            end
        end
    end

    always @(posedge clk_i)
    begin
        if (ce_i && push_i)
            mem_reg[sp_reg] <= push_addr_i;
    end

endmodule
`default_nettype wire

// ---- rtl/branch_predict_speculation_ctrl.v ----
// Branch prediction, speculation level and checkpoint control, FP queue
// handoff, speculative write buffering and memory data bypass.
// Assumes all inputs come from pipeline logic on sys_clk_i.
`timescale 1ns/10ps
`default_nettype none
`include "branch_spec_defines.vh"

module branch_predict_speculation_ctrl
#(
    parameter AW = 32,
    parameter DW = 32
)
(
    // Clock, reset, enable
    input  wire          sys_clk_i,
    input  wire          rst_n_i,
    input  wire          ce_i,
    // Fetch
    input  wire          fetch_valid_i,
    input  wire [AW-1:0] fetch_pc_i,
    input  wire [AW-1:0] fetch_seq_pc_i,
    input  wire          fetch_is_uncond_i,
    input  wire          fetch_is_cond_i,
    input  wire          fetch_is_call_i,
    input  wire          fetch_is_return_instruction_i,
    output wire          fetch_redirect_o,
    output wire [AW-1:0] fetch_target_o,
    output wire [AW-1:0] fetch_alt_o,
    output wire          pred_taken_o,
    output wire          fetch_stall_o,
    // Decode and issue
    input  wire          dec_cond_branch_i,
    input  wire          dec_fp_i,
    output wire          issue_secondary_ok_o,
    // Resolution
    input  wire          resolve_valid_i,
    input  wire          resolve_cond_i,
    input  wire          cc_parallel_i,
    input  wire [AW-1:0] resolve_pc_i,
    input  wire          resolve_taken_i,
    input  wire [AW-1:0] resolve_target_i,
    output wire          resolve_in_writeback_stage_o,
    output wire          flush_o,
    output wire [AW-1:0] flush_target_o,
    // Speculation
    input  wire          exception_i,
    input  wire          nockpt_write_i,
    output wire          ckpt_save_o,
    output wire          ckpt_release_o,
    output wire          ckpt_restore_o,
    output wire          spec_halt_o,
    output wire [2:0]    spec_level_o,
    // Floating point handoff
    input  wire          fp_ac2_valid_i,
    input  wire          fp_mmu_fault_i,
    input  wire          fp_done_i,
    output wire          fp_dispatch_o,
    output wire [2:0]    fp_queue_count_o,
    // Stores and memory writes
    input  wire          st_valid_i,
    input  wire [AW-1:0] st_addr_i,
    input  wire [DW-1:0] st_data_i,
    output wire          st_ready_o,
    output wire          mem_wr_valid_o,
    output wire [AW-1:0] mem_wr_addr_o,
    output wire [DW-1:0] mem_wr_data_o,
    input  wire          mem_wr_ready_i,
    // Memory data bypass
    input  wire          x_mem_wr_i,
    input  wire [AW-1:0] x_addr_i,
    input  wire [DW-1:0] x_result_i,
    input  wire          y_mem_rd_i,
    input  wire [AW-1:0] y_addr_i,
    input  wire          cacheable_i,
    output wire          y_stall_o,
    output wire          y_mem_rd_en_o,
    output reg           y_bypass_o,
    output reg  [DW-1:0] y_bypass_data_o
);

    localparam SETS = `BTB_ENTRIES / `BTB_WAYS;
    localparam SB   = `BTB_SET_BITS;
    localparam TB   = AW - SB - `PC_IDX_LSB;
    localparam BHTN = 1 << `BHT_IDX_BITS;

    // Reset release
    reg rst_s1_reg;
    reg rst_s2_reg;
    wire rst_n;
    always @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end
        else
        begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    assign rst_n = rst_s2_reg;

    function [1:0] ctr_update;
        input [1:0] c;
        input       t;
        begin
            if (t)
                ctr_update = (c == 2'h3) ? c : c + 2'h1;
            else
                ctr_update = (c == 2'h0) ? c : c - 2'h1;
        end
    endfunction

    function [2:0] inc6;
        input [2:0] p;
        begin
            inc6 = (p == `WBUF_DEPTH - 3'h1) ? 3'h0 : p + 3'h1;
        end
    endfunction

    function [SB-1:0] set_of;
        input [AW-1:0] a;
        begin
            set_of = a[`PC_IDX_LSB +: SB];
        end
    endfunction

    function [TB-1:0] tag_of;
        input [AW-1:0] a;
        begin
            tag_of = a[AW-1 -: TB];
        end
    endfunction

    // Target buffer and history table
    reg [`BTB_WAYS-1:0] btb_v_reg [0:SETS-1];
    reg [TB-1:0]        btb_tag_reg [0:`BTB_WAYS*SETS-1];
    reg [AW-1:0]        btb_tgt_reg [0:`BTB_WAYS*SETS-1];
    reg [1:0]           bht_reg [0:BHTN-1];
    reg [1:0]           victim_reg;

    wire [SB-1:0]        f_set = set_of(fetch_pc_i);
    wire [SB-1:0]        r_set = set_of(resolve_pc_i);
    wire [`BTB_WAYS-1:0] f_hit_w;
    wire [`BTB_WAYS-1:0] r_hit_w;
    reg  [AW-1:0]        f_tgt;
    reg  [1:0]           r_way;
    integer k, vk, ck, dk;

    genvar w;
    generate
        for (w = 0; w < `BTB_WAYS; w = w + 1)
        begin : g_way
            assign f_hit_w[w] = btb_v_reg[f_set][w] &&
                btb_tag_reg[w*SETS + f_set] == tag_of(fetch_pc_i);
            assign r_hit_w[w] = btb_v_reg[r_set][w] &&
                btb_tag_reg[w*SETS + r_set] == tag_of(resolve_pc_i);
        end
    endgenerate

    always @*
    begin
        f_tgt = {AW{1'b0}};
        r_way = victim_reg;
        for (k = 0; k < `BTB_WAYS; k = k + 1)
        begin
            if (f_hit_w[k])
                f_tgt = btb_tgt_reg[k*SETS + f_set];
            if (r_hit_w[k])
                r_way = k[1:0];
        end
    end

    wire f_hit = |f_hit_w;
    wire [1:0] f_ctr = bht_reg[fetch_pc_i[`PC_IDX_LSB +: `BHT_IDX_BITS]];
    wire cond_taken = f_hit && f_ctr[`CTR_TAKEN_BIT];

    // Return stack
    wire rs_nonempty;
    wire [AW-1:0] rs_top;
    wire fetch_go = fetch_valid_i && !fetch_stall_o;
    wire ret_hit = fetch_go && fetch_is_return_instruction_i && rs_nonempty;

    return_stack #(.AW(AW), .DEPTH(`RSTACK_DEPTH)) u_rstack
    (
        .clk_i       (sys_clk_i),
        .rst_n_i     (rst_n),
        .ce_i        (ce_i),
        .push_i      (fetch_go && fetch_is_call_i),
        .push_addr_i (fetch_seq_pc_i),
        .pop_i       (ret_hit),
        .nonempty_o  (rs_nonempty),
        .top_o       (rs_top)
    );

    // Speculation state
    reg [2:0]    level_reg;
    reg [2:0]    fpq_reg;
    reg [2:0]    pen_reg;
    reg [1:0]    bs_head_reg;
    reg [1:0]    bs_tail_reg;
    reg [2:0]    bs_cnt_reg;
    reg          bs_pred_reg [0:3];
    reg [AW-1:0] bs_seq_reg [0:3];

    wire level_full = (level_reg == `SPEC_MAX_LEVEL);
    wire wbuf_full;
    assign spec_halt_o = (level_full && (dec_cond_branch_i || dec_fp_i)) ||
        exception_i || wbuf_full || (nockpt_write_i && level_reg != 3'h0);

    wire res_cond = resolve_valid_i && resolve_cond_i && bs_cnt_reg != 3'h0;
    wire head_pred = bs_pred_reg[bs_head_reg];
    wire mispredict = res_cond && (resolve_taken_i != head_pred);
    assign flush_o = mispredict;
    assign flush_target_o = resolve_taken_i ? resolve_target_i
                                            : bs_seq_reg[bs_head_reg];
    assign resolve_in_writeback_stage_o = cc_parallel_i;

    wire fp_push = fp_ac2_valid_i && !fp_mmu_fault_i && !level_full &&
        fpq_reg != `FPQ_DEPTH && !spec_halt_o && !mispredict;
    wire [2:0] lvl_after_fp = level_reg + {2'h0, fp_push};
    wire br_need = fetch_valid_i && fetch_is_cond_i && pen_reg == 3'h0;
    wire br_push = br_need && lvl_after_fp != `SPEC_MAX_LEVEL &&
        !exception_i && !wbuf_full && !mispredict;
    wire fp_rel = fp_done_i && level_reg != 3'h0;
    wire br_rel = res_cond && !mispredict;
    wire [2:0] rel = {2'h0, fp_rel} + {2'h0, br_rel};

    assign fetch_stall_o = (pen_reg != 3'h0) || (br_need && !br_push);
    assign ckpt_save_o = fp_push || br_push;
    assign ckpt_release_o = fp_rel || br_rel;
    assign ckpt_restore_o = mispredict;
    assign spec_level_o = level_reg;
    assign fp_dispatch_o = fp_push;
    assign fp_queue_count_o = fpq_reg;
    assign issue_secondary_ok_o = !dec_cond_branch_i;

    // Fetch redirect
    wire uncond_hit = fetch_go && fetch_is_uncond_i && f_hit;
    wire cond_red = br_push && cond_taken;
    assign fetch_redirect_o = mispredict || ret_hit || uncond_hit || cond_red;
    assign fetch_target_o = mispredict ? flush_target_o :
                            ret_hit ? rs_top : f_tgt;
    assign pred_taken_o = cond_taken;
    assign fetch_alt_o = cond_taken ? fetch_seq_pc_i : f_tgt;

    always @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            level_reg   <= 3'h0;
            fpq_reg     <= 3'h0;
            pen_reg     <= 3'h0;
            bs_head_reg <= 2'h0;
            bs_tail_reg <= 2'h0;
            bs_cnt_reg  <= 3'h0;
            victim_reg  <= 2'h0;
        end
        else if (ce_i)
        begin
            if (mispredict)
            begin
                level_reg   <= 3'h0;
                bs_cnt_reg  <= 3'h0;
                bs_tail_reg <= bs_head_reg;
                pen_reg <= cc_parallel_i ? `PENALTY_WB : `PENALTY_EX;
            end
            else
            begin
                level_reg <= level_reg + {2'h0, fp_push} + {2'h0, br_push}
                             - rel;
                bs_cnt_reg <= bs_cnt_reg + {2'h0, br_push} - {2'h0, br_rel};
                if (br_push)
                    bs_tail_reg <= bs_tail_reg + 2'h1;
                if (br_rel)
                    bs_head_reg <= bs_head_reg + 2'h1;
                if (pen_reg != 3'h0)
                    pen_reg <= pen_reg - 3'h1;
            end
            if (fp_push != (fp_done_i && fpq_reg != 3'h0))
                fpq_reg <= fp_push ? fpq_reg + 3'h1 : fpq_reg - 3'h1;
            if (resolve_valid_i && resolve_taken_i && r_hit_w == 4'h0)
                victim_reg <= victim_reg + 2'h1;
        end
    end

    // Table updates on resolution, branch stack writes on fetch
    always @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (vk = 0; vk < SETS; vk = vk + 1)
                btb_v_reg[vk] <= 4'h0;
        end
        else if (ce_i && resolve_valid_i && resolve_taken_i)
            btb_v_reg[r_set][r_way] <= 1'b1;
    end

    always @(posedge sys_clk_i)
    begin
        if (ce_i)
        begin
            if (br_push)
            begin
                bs_pred_reg[bs_tail_reg] <= cond_taken;
                bs_seq_reg[bs_tail_reg]  <= fetch_seq_pc_i;
            end
            if (resolve_valid_i && resolve_taken_i)
            begin
                btb_tag_reg[r_way*SETS + r_set] <= tag_of(resolve_pc_i);
                btb_tgt_reg[r_way*SETS + r_set] <= resolve_target_i;
            end
            if (resolve_valid_i && resolve_cond_i)
            begin
                bht_reg[resolve_pc_i[`PC_IDX_LSB +: `BHT_IDX_BITS]] <=
                    (resolve_taken_i && r_hit_w == 4'h0) ? `CTR_RESET + 2'h1 :
                    ctr_update(bht_reg[resolve_pc_i[`PC_IDX_LSB +: `BHT_IDX_BITS]],
                               resolve_taken_i);
            end
        end
    end

    // Write buffer: depth tag counts levels still governing each write
    reg [AW-1:0] wb_addr_reg [0:5];
    reg [DW-1:0] wb_data_reg [0:5];
    reg [2:0]    wb_dep_reg [0:5];
    reg [2:0]    wb_head_reg;
    reg [2:0]    wb_tail_reg;
    reg [2:0]    wb_cnt_reg;
    reg [2:0]    n_commit;
    reg [2:0]    idx;

    assign wbuf_full = (wb_cnt_reg == `WBUF_DEPTH);
    assign st_ready_o = !wbuf_full && !mispredict;
    wire enq = st_valid_i && st_ready_o;
    wire head_ok = wb_cnt_reg != 3'h0 && wb_dep_reg[wb_head_reg] == 3'h0;
    assign mem_wr_valid_o = head_ok;
    assign mem_wr_addr_o = wb_addr_reg[wb_head_reg];
    assign mem_wr_data_o = wb_data_reg[wb_head_reg];
    wire deq = head_ok && mem_wr_ready_i;
    wire [2:0] st_dep = level_reg - rel;
    // Kept region end, one bit wider so the wrap is not lost
    wire [3:0] keep_end  = {1'b0, wb_head_reg} + {1'b0, n_commit};
    wire [3:0] keep_wrap = keep_end - {1'b0, `WBUF_DEPTH};

    always @*
    begin
        n_commit = 3'h0;
        idx = wb_head_reg;
        for (ck = 0; ck < 6; ck = ck + 1)
        begin
            if (ck[2:0] < wb_cnt_reg && wb_dep_reg[idx] == 3'h0)
                n_commit = n_commit + 3'h1;
            idx = inc6(idx);
        end
    end

    always @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wb_head_reg <= 3'h0;
            wb_tail_reg <= 3'h0;
            wb_cnt_reg  <= 3'h0;
        end
        else if (ce_i)
        begin
            if (deq)
                wb_head_reg <= inc6(wb_head_reg);
            if (mispredict)
            begin
                wb_cnt_reg <= n_commit - {2'h0, deq};
                wb_tail_reg <= keep_wrap[3] ? keep_end[2:0] : keep_wrap[2:0];
            end
            else
            begin
                wb_cnt_reg <= wb_cnt_reg + {2'h0, enq} - {2'h0, deq};
                if (enq)
                    wb_tail_reg <= inc6(wb_tail_reg);
            end
        end
    end

    always @(posedge sys_clk_i)
    begin
        if (ce_i)
        begin
            for (dk = 0; dk < 6; dk = dk + 1)
            begin
                if (rel != 3'h0 && wb_dep_reg[dk] != 3'h0)
                    wb_dep_reg[dk] <= (wb_dep_reg[dk] > rel) ?
                                      wb_dep_reg[dk] - rel : 3'h0;
            end
            if (enq)
            begin
                wb_addr_reg[wb_tail_reg] <= st_addr_i;
                wb_data_reg[wb_tail_reg] <= st_data_i;
                wb_dep_reg[wb_tail_reg]  <= st_dep;
            end
        end
    end

    // Memory data bypass between paired instructions
    reg bp_pend_reg;
    wire bp_hit = x_mem_wr_i && y_mem_rd_i && x_addr_i == y_addr_i &&
                  cacheable_i && !bp_pend_reg;
    assign y_stall_o = bp_hit;
    assign y_mem_rd_en_o = y_mem_rd_i && !bp_hit && !bp_pend_reg;

    always @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bp_pend_reg     <= 1'b0;
            y_bypass_o      <= 1'b0;
            y_bypass_data_o <= {DW{1'b0}};
        end
        else if (ce_i)
        begin
            bp_pend_reg <= bp_hit;
            y_bypass_o  <= bp_hit;
            if (bp_hit)
                y_bypass_data_o <= x_result_i;
        end
    end

endmodule
`default_nettype wire

// ---- verif/branch_spec_ctrl_asserts.sv ----
// Checker for the branch prediction and speculation control block.
// Bound to the top module; sees its ports only, one clock domain.
`timescale 1ns/10ps
`default_nettype none
module branch_spec_ctrl_asserts
#(
    parameter AW = 32,
    parameter DW = 32
)
(
    // Clock and reset
    input wire logic          sys_clk_i, rst_n_i, ce_i,
    // Issue and resolution
    input wire logic          dec_cond_branch_i, issue_secondary_ok_o, cc_parallel_i,
    input wire logic          resolve_in_writeback_stage_o, flush_o, fetch_stall_o,
    input wire logic          resolve_taken_i, fetch_redirect_o,
    input wire logic [AW-1:0] resolve_target_i, flush_target_o,
    // Speculation and floating point
    input wire logic [2:0]    spec_level_o, fp_queue_count_o,
    input wire logic          fp_dispatch_o, fp_mmu_fault_i, exception_i, spec_halt_o,
    // Bypass
    input wire logic          x_mem_wr_i, y_mem_rd_i, cacheable_i,
    input wire logic [AW-1:0] x_addr_i, y_addr_i,
    input wire logic [DW-1:0] x_result_i, y_bypass_data_o,
    input wire logic          y_stall_o, y_mem_rd_en_o, y_bypass_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    wire pair_hit = ce_i && x_mem_wr_i && y_mem_rd_i && x_addr_i == y_addr_i &&
                    cacheable_i && !y_bypass_o;

    issue_primary_a: assert property (dec_cond_branch_i |-> !issue_secondary_ok_o)
        else $error("conditional branch offered to secondary pipe");
    bypass_pass_a: assert property (pair_hit |-> y_stall_o && !y_mem_rd_en_o ##1
        y_bypass_o && !y_mem_rd_en_o && y_bypass_data_o == $past(x_result_i))
        else $error("memory data bypass wrong");
    uncached_read_a: assert property (!cacheable_i && !y_bypass_o |->
        y_mem_rd_en_o == y_mem_rd_i) else $error("uncached read not issued");
    wb_stage_a: assert property (resolve_in_writeback_stage_o == cc_parallel_i)
        else $error("resolution stage wrong");
    penalty_ex_a: assert property (ce_i && flush_o && !cc_parallel_i |=>
        fetch_stall_o [*4] ##1 !fetch_stall_o) else $error("execute penalty not four");
    penalty_wb_a: assert property (ce_i && flush_o && cc_parallel_i |=>
        fetch_stall_o [*5] ##1 !fetch_stall_o) else $error("writeback penalty not five");
    flush_dest_a: assert property (flush_o && resolve_taken_i |->
        fetch_redirect_o && flush_target_o == resolve_target_i) else $error("flush target wrong");
    fp_gate_a: assert property (fp_dispatch_o |-> !fp_mmu_fault_i &&
        spec_level_o < 3'h4 && fp_queue_count_o < 3'h4) else $error("fp dispatch not allowed");
    level_cap_a: assert property (spec_level_o <= 3'h4)
        else $error("speculation level above four");
    halt_cause_a: assert property (exception_i || (spec_level_o == 3'h4 &&
        dec_cond_branch_i) |-> spec_halt_o) else $error("speculation not halted");

    cover property (pair_hit);
    cover property (flush_o && cc_parallel_i);
    cover property (fp_queue_count_o == 3'h4);
endmodule
bind branch_predict_speculation_ctrl branch_spec_ctrl_asserts #(.AW(AW), .DW(DW)) u_chk (.*);
`default_nettype wire

// ---- verif/branch_predict_speculation_ctrl_test.sv ----
// Self-checking bench for the branch prediction and speculation block.
// Assumes default widths of 32 bits; the bench acts as the whole pipeline.
`timescale 1ns/10ps
`default_nettype none
module branch_predict_speculation_ctrl_test;
    logic        sys_clk_i, rst_n_i, ce_i, fetch_valid_i, fetch_is_uncond_i, fetch_is_cond_i;
    logic        fetch_is_call_i, fetch_is_return_instruction_i, fetch_redirect_o, pred_taken_o;
    logic        fetch_stall_o, dec_cond_branch_i, dec_fp_i, issue_secondary_ok_o;
    logic        resolve_valid_i, resolve_cond_i, cc_parallel_i, resolve_taken_i, flush_o;
    logic        resolve_in_writeback_stage_o, exception_i, nockpt_write_i, ckpt_save_o;
    logic        ckpt_release_o, ckpt_restore_o, spec_halt_o, fp_ac2_valid_i, fp_mmu_fault_i;
    logic        fp_done_i, fp_dispatch_o, st_valid_i, st_ready_o, mem_wr_valid_o;
    logic        mem_wr_ready_i, x_mem_wr_i, y_mem_rd_i, cacheable_i, y_stall_o;
    logic        y_mem_rd_en_o, y_bypass_o;
    logic [31:0] fetch_pc_i, fetch_seq_pc_i, fetch_target_o, fetch_alt_o, resolve_pc_i;
    logic [31:0] resolve_target_i, flush_target_o, st_addr_i, st_data_i, mem_wr_addr_o;
    logic [31:0] mem_wr_data_o, x_addr_i, x_result_i, y_addr_i, y_bypass_data_o;
    logic [2:0]  spec_level_o, fp_queue_count_o;
    int          num_errors, cmp_count;

    branch_predict_speculation_ctrl DUT (.*);

    initial
    begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Drops every strobe at the next clock edge and leaves it low
    task automatic clr;
        @(posedge sys_clk_i);
        {fetch_valid_i, resolve_valid_i, fp_ac2_valid_i, fp_done_i, st_valid_i} <= '0;
        {x_mem_wr_i, y_mem_rd_i, dec_fp_i, dec_cond_branch_i, fp_mmu_fault_i} <= '0;
        {exception_i, nockpt_write_i} <= '0;
        #1;
    endtask

    // Kind is uncond, cond, call, return
    task automatic fetch(input logic [3:0] k, input logic [31:0] pc);
        @(posedge sys_clk_i);
        resolve_valid_i <= 1'b0;
        {fetch_valid_i, fetch_is_uncond_i, fetch_is_cond_i, fetch_is_call_i,
            fetch_is_return_instruction_i} <= {1'b1, k};
        fetch_pc_i <= pc;
        fetch_seq_pc_i <= pc + 32'h4;
        #1;
    endtask

    task automatic resolve(input logic tk, input logic cc, input logic [31:0] pc, tgt);
        @(posedge sys_clk_i);
        fetch_valid_i <= 1'b0;
        {resolve_valid_i, resolve_cond_i, resolve_taken_i, cc_parallel_i} <= {2'b11, tk, cc};
        resolve_pc_i <= pc;
        resolve_target_i <= tgt;
        #1;
    endtask

    task automatic wait_stall(input int exp);
        int n;
        clr;
        n = 0;
        while (fetch_stall_o === 1'b1 && n < 10)
        begin
            n++;
            @(posedge sys_clk_i);
            #1;
        end
        check(n, exp);
    endtask

    task automatic t_bypass;
        @(posedge sys_clk_i);
        {x_mem_wr_i, y_mem_rd_i, cacheable_i} <= 3'b111;
        {x_addr_i, y_addr_i, x_result_i} <= {32'h0000_0100, 32'h0000_0100, 32'h0000_a5a5};
        #1;
        check({y_stall_o, y_mem_rd_en_o}, 2'b10);
        @(posedge sys_clk_i);
        cacheable_i <= 1'b0;
        #1;
        check({y_bypass_o, y_mem_rd_en_o}, 2'b10);
        check(y_bypass_data_o, 32'h0000_a5a5);
        @(posedge sys_clk_i);
        #1;
        check({y_stall_o, y_mem_rd_en_o, y_bypass_o}, 3'b010);
        clr;
    endtask

    task automatic t_mispredict(input logic cc, input logic [31:0] pc, tgt);
        fetch(4'b0100, pc);
        check({fetch_redirect_o, pred_taken_o}, 2'b00);
        resolve(1'b1, cc, pc, tgt);
        check({flush_o, ckpt_restore_o, flush_target_o}, {2'b11, tgt});
        check(resolve_in_writeback_stage_o, cc);
        wait_stall(cc ? 5 : 4);
        check(spec_level_o, 3'h0);
    endtask

    task automatic t_predict;
        fetch(4'b1000, 32'h0000_0040);
        check({fetch_redirect_o, fetch_target_o}, {1'b1, 32'h0000_0800});
        fetch(4'b0100, 32'h0000_0040);
        check({fetch_redirect_o, pred_taken_o, ckpt_save_o}, 3'b111);
        check(fetch_target_o, 32'h0000_0800);
        check(fetch_alt_o, 32'h0000_0044);
        clr;
        check(spec_level_o, 3'h1);
        resolve(1'b1, 1'b0, 32'h0000_0040, 32'h0000_0800);
        check({flush_o, ckpt_release_o}, 2'b01);
        clr;
        check({fetch_stall_o, spec_level_o}, 4'h0);
        fetch(4'b0100, 32'h0000_0040);
        resolve(1'b0, 1'b0, 32'h0000_0040, 32'h0000_0800);
        check({flush_o, flush_target_o}, {1'b1, 32'h0000_0044});
        wait_stall(4);
        fetch(4'b0100, 32'h0000_0040);
        check(pred_taken_o, 1'b1);
        resolve(1'b1, 1'b0, 32'h0000_0040, 32'h0000_0800);
        clr;
    endtask

    task automatic t_fp;
        for (int i = 0; i < 4; i++)
        begin
            @(posedge sys_clk_i);
            fp_ac2_valid_i <= 1'b1;
            #1;
            check(fp_dispatch_o, 1'b1);
        end
        @(posedge sys_clk_i);
        dec_fp_i <= 1'b1;
        #1;
        check({fp_dispatch_o, spec_halt_o}, 2'b01);
        check({spec_level_o, fp_queue_count_o}, 6'h24);
        @(posedge sys_clk_i);
        {ce_i, fp_ac2_valid_i, dec_fp_i, fp_done_i} <= 4'b0001;
        @(posedge sys_clk_i);
        ce_i <= 1'b1;
        #1;
        check(spec_level_o, 3'h4);
        repeat (4) @(posedge sys_clk_i);
        {fp_ac2_valid_i, fp_mmu_fault_i, fp_done_i} <= 3'b110;
        #1;
        check({spec_level_o, fp_queue_count_o}, 6'h00);
        check(fp_dispatch_o, 1'b0);
        clr;
    endtask

    task automatic t_store;
        int n;
        fetch(4'b0010, 32'h0000_0200);
        fetch(4'b0001, 32'h0000_0300);
        check({fetch_redirect_o, fetch_target_o}, {1'b1, 32'h0000_0204});
        fp_ac2_valid_i <= 1'b1;
        clr;
        nockpt_write_i <= 1'b1;
        #1;
        check(spec_halt_o, 1'b1);
        for (int i = 0; i < 7; i++)
        begin
            @(posedge sys_clk_i);
            {nockpt_write_i, st_valid_i} <= 2'b01;
            {st_addr_i, st_data_i} <= {32'h0000_1000 + i * 4, 32'h0000_5a00 + i};
            #1;
            check(st_ready_o, i < 6);
        end
        check({spec_halt_o, mem_wr_valid_o}, 2'b10);
        @(posedge sys_clk_i);
        {st_valid_i, fp_done_i, mem_wr_ready_i} <= 3'b011;
        clr;
        for (int k = 0; k < 6; k++)
        begin
            n = 0;
            while (mem_wr_valid_o !== 1'b1 && n < 8)
            begin
                n++;
                @(posedge sys_clk_i);
                #1;
            end
            check({mem_wr_addr_o, mem_wr_data_o}, {32'h0000_1000 + k * 4, 32'h0000_5a00 + k});
            @(posedge sys_clk_i);
            #1;
        end
        check({mem_wr_valid_o, st_ready_o}, 2'b01);
    endtask

    initial
    begin
        {rst_n_i, fetch_valid_i, resolve_valid_i, fp_ac2_valid_i, fp_done_i, st_valid_i} = '0;
        {x_mem_wr_i, y_mem_rd_i, dec_fp_i, dec_cond_branch_i, fp_mmu_fault_i} = '0;
        {exception_i, nockpt_write_i, cacheable_i, mem_wr_ready_i, resolve_cond_i} = '0;
        {fetch_is_uncond_i, fetch_is_cond_i, fetch_is_call_i} = '0;
        {fetch_is_return_instruction_i, cc_parallel_i, resolve_taken_i} = '0;
        {fetch_pc_i, fetch_seq_pc_i, resolve_pc_i, resolve_target_i} = '0;
        {st_addr_i, st_data_i, x_addr_i, x_result_i, y_addr_i} = '0;
        ce_i = 1'b1;
        repeat (12) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        #1;
        check({spec_level_o, fp_queue_count_o, fetch_stall_o, mem_wr_valid_o}, 8'h00);
        @(posedge sys_clk_i);
        {dec_cond_branch_i, exception_i} <= 2'b11;
        #1;
        check({issue_secondary_ok_o, spec_halt_o}, 2'b01);
        t_bypass;
        t_mispredict(1'b0, 32'h0000_0040, 32'h0000_0800);
        t_predict;
        t_mispredict(1'b1, 32'h0000_0080, 32'h0000_0900);
        t_fp;
        t_store;
        report_and_stop;
    end

    initial
    begin
        #(4 * 5000);
        num_errors++;
        report_and_stop;
    end
endmodule
`default_nettype wire
